// [bdpi_far_model.sv]
// Far-side glue model: ready, burst acknowledge and wake pulses
module bdpi_far_model
(
  input wire logic clk_i,
  input wire logic go_i,       // Start one bus answer
  input wire logic ack_i,      // Answer with burst acknowledge
  input wire logic slow_i,     // Add wait clocks before answering
  input wire logic wake_i,     // Request one wake pulse
  input wire logic power_down_indication_n_i,  // Power-down indication from device
  output logic ready_n_o,
  output logic burst_ack_n_o,
  output logic wake_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Answer process, lines idle at pull-up level
  // ----
  initial
  begin
    ready_n_o = 1'b1;
    burst_ack_n_o = 1'b1;
    wake_n_o = 1'b1;
    forever
    begin
      @(posedge clk_i);
      if (go_i)
      begin
        @(negedge clk_i);
        if (slow_i)
          repeat (3) @(negedge clk_i); // Slow answer
        burst_ack_n_o = !ack_i;
        @(negedge clk_i);
        ready_n_o = 1'b0;
        repeat (5) @(negedge clk_i);
        ready_n_o = 1'b1;
        burst_ack_n_o = 1'b1;
      end
      else if (wake_i && !power_down_indication_n_i)
      begin
        @(negedge clk_i);
        wake_n_o = 1'b0;
        repeat (3) @(negedge clk_i);
        wake_n_o = 1'b1;
      end
    end
  end
endmodule

// [bdpi_pkg.sv]
// Constants and types shared by the burst DRAM pin interface
// Function
// - Float low puts every pin high-impedance
// - Burst request on enabled eligible or DRAM burst
// - DRAM burst enable forces burst without acknowledge
// - Page compare under mask drives page-hit
// - No page-hit in first cycle after handover
// - 32-bit two-strobe: strobe per byte lane
// - 16-bit: strobe 2 even, 3 odd
// - Two-write-enable: all column strobes identical
// - Write enables per lane, or all identical
// - Provide DRAM output enable pin
// - Refresh timer counts down, pulses overflow low
// - Refresh timer runs on input clock
// - Preload bit 31 picks one or three clocks
// - Reset drives listed control pins high
// - Bus grant floats and holds listed pins
// - Grant drives captured address until ready
package bdpi_pkg;
  // ---------------------------------------------------------------
  // Field positions in the settings words
  // ---------------------------------------------------------------
  localparam int SYSTEM_SUPPORT_CONTROL_SETTINGS_PAGE_EN_BIT = 5;     // Page-hit detection enable
  localparam int SYSTEM_SUPPORT_CONTROL_SETTINGS_DRAM_BURST_BIT = 6;  // DRAM burst enable
  localparam int SYSTEM_SUPPORT_CONTROL_SETTINGS_REFRESH_EN_BIT = 7;  // Refresh timer enable
  localparam int PRELOAD_WIDTH_BIT = 31;   // Overflow pulse width select
  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int ADDR_W = 26;              // Address pins 27:2
  localparam int CNT_W = 31;               // Refresh period field
  localparam logic [1:0] OVF_SHORT = 2'h1; // One-clock overflow pulse
  localparam logic [1:0] OVF_LONG = 2'h3;  // Three-clock overflow pulse
  localparam logic [1:0] WAKE_MIN_CYC = 2'h2; // Least wake pulse in clocks
  localparam logic [3:0] ALL_HIGH4 = 4'hf; // Idle strobe pattern
  localparam logic [5:0] ALL_HIGH6 = 6'h3f; // Idle chip selects
  // Power state of the core
  typedef enum logic {BDPI_AWAKE, BDPI_ASLEEP} bdpi_pwr_t;
endpackage

// [bdpi_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
module bdpi_sync
  import bdpi_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q; // First stage, read only by second
  logic [W-1:0] sync_q; // Second stage
  // ---------------------------------------------------------------
  // Register chain, idle level high after reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule

// [bdpi_top.sv]
// Burst DRAM pin interface: sleep, float, burst, page-hit, strobes, timer
module bdpi_top
  import bdpi_pkg::*;
(
  input wire logic clk_i,                 // Input clock, bus rate
  input wire logic sys_rst_i,             // Synchronous reset
  input wire logic wake_n_i,              // Wake pin, async
  input wire logic float_n_i,             // Float pin, async
  input wire logic burst_ack_n_i,         // Burst acknowledge pin
  input wire logic ready_n_i,             // Ready pin
  input wire logic ext_as_n_i,            // Address strobe from other master
  input wire logic [ADDR_W-1:0] ext_addr_i, // Address from other master
  input wire logic sleep_req_i,           // Core enters sleep
  input wire logic grant_i,               // Bus handed to other master
  input wire logic [31:0] bus_ctrl_i,     // bus_control_settings burst bit
  input wire logic xact_burst_ok_i,       // Current transaction may burst
  input wire logic [31:0] system_support_control_settings_i,         // system_support_control_settings
  input wire logic [31:0] preload_i,      // Refresh preload setting
  input wire logic [ADDR_W-1:0] page_mask_i, // Page compare mask
  input wire logic cycle_start_i,         // Core starts bus cycle
  input wire logic [ADDR_W-1:0] core_addr_i, // Core address
  input wire logic [3:0] be_n_i,          // Core byte enables
  input wire logic as_n_i,                // Core address strobe
  input wire logic read_write_output_i,                // Core read/write
  input wire logic [3:0] asi_i,           // Core address space
  input wire logic lock_n_i,              // Core lock
  input wire logic error_n_i,             // Core error
  input wire logic [5:0] cs_n_i,          // Core chip selects
  input wire logic [31:0] data_i,         // Core write data
  input wire logic data_drive_i,          // Core drives data bus
  input wire logic dram_ctrl_en_i,        // DRAM controller enabled
  input wire logic dram_area_i,           // Captured address maps to DRAM
  input wire logic [ADDR_W-1:0] mux_addr_i, // Multiplexed DRAM address
  input wire logic [3:0] ras_n_i,         // Controller row strobes
  input wire logic cas_act_i,             // Controller column strobe timing
  input wire logic we_act_i,              // Controller write timing
  input wire logic oe_act_i,              // Controller output enable timing
  input wire logic [3:0] lane_i,          // Lane select, bit0 = b31-b24
  input wire logic bus16_i,               // 16-bit DRAM bus
  input wire logic two_we_i,              // Two-write-enable arrangement
  output logic burst_mode_o,              // Burst transfer taken
  output logic asleep_o,                  // Core held asleep
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe_o,
  output logic [3:0] be_n_o,
  output logic be_oe_o,
  output logic as_n_o,
  output logic read_write_output_o,
  output logic [3:0] asi_o,
  output logic bus_oe_o,                  // Enables address strobe, read_write_output, asi
  output logic lock_n_o,
  output logic lock_oe_o,
  output logic [5:0] cs_n_o,
  output logic cs_oe_o,
  output logic [31:0] data_o,
  output logic data_oe_o,
  output logic error_n_o,
  output logic power_down_indication_n_o,                 // power_down_indication
  output logic bus_grant_output_n_o,                 // bus_grant_output
  output logic page_hit_n_o,              // page_hit_output
  output logic burst_req_n_o,             // burst_request
  output logic tovf_n_o,                  // refresh_timer_overflow
  output logic [3:0] ras_n_o,
  output logic [3:0] cas_n_o,
  output logic [3:0] dwe_n_o,             // dram_write_enables
  output logic doe_n_o,                   // dram_output_enable
  output logic ctl_oe_o                   // Enables the always-driven pins
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic wake_s, float_s, ack_s, ready_s, ext_as_s;
  logic [ADDR_W-1:0] ext_addr_s;
  bdpi_sync #(.W(5)) u_sync_ctl (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({wake_n_i, float_n_i, burst_ack_n_i, ready_n_i, ext_as_n_i}),
    .sync_o({wake_s, float_s, ack_s, ready_s, ext_as_s})
  );
  bdpi_sync #(.W(ADDR_W)) u_sync_addr (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(ext_addr_i),
    .sync_o(ext_addr_s)
  );
  // ---------------------------------------------------------------
  // Sleep and wake
  // ---------------------------------------------------------------
  bdpi_pwr_t pwr_q, pwr_d;
  logic [1:0] wake_cnt_q, wake_cnt_d; // Clocks of wake held low
  // Wake counts only while asleep; the far side keeps it high otherwise
  always_comb
  begin
    pwr_d = pwr_q;
    wake_cnt_d = 2'h0;
    unique case (pwr_q)
      BDPI_AWAKE:
      begin
        if (sleep_req_i)
          pwr_d = BDPI_ASLEEP;
      end
      BDPI_ASLEEP:
      begin
        if (!wake_s)
        begin
          if (wake_cnt_q == WAKE_MIN_CYC - 2'h1)
            pwr_d = BDPI_AWAKE;
          else
            wake_cnt_d = wake_cnt_q + 2'h1;
        end
      end
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pwr_q <= BDPI_AWAKE;
      wake_cnt_q <= 2'h0;
    end
    else
    begin
      pwr_q <= pwr_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end
  assign asleep_o = (pwr_q == BDPI_ASLEEP);
  // ---------------------------------------------------------------
  // Page-hit tracking and captured address during grant
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] prev_addr_q, prev_addr_d; // Last accessed address
  logic first_q, first_d;       // First cycle after ownership change
  logic grant_q;                // Grant one clock ago
  logic hit_q, hit_d;           // Page-hit result
  logic as_prev_q;              // Other master strobe one clock ago
  logic hold_q, hold_d;         // Driving captured address
  logic [ADDR_W-1:0] cap_q, cap_d; // Captured address
  always_comb
  begin
    prev_addr_d = prev_addr_q;
    first_d = first_q;
    hit_d = hit_q;
    if (cycle_start_i)
    begin
      prev_addr_d = core_addr_i;
      first_d = 1'b0;
      hit_d = system_support_control_settings_i[SYSTEM_SUPPORT_CONTROL_SETTINGS_PAGE_EN_BIT] && !first_q
              && (((core_addr_i ^ prev_addr_q) & page_mask_i) == '0);
    end
    if (grant_i != grant_q)
    begin
      first_d = 1'b1;
      hit_d = 1'b0;
    end
    cap_d = cap_q;
    hold_d = hold_q;
    if (grant_i && dram_ctrl_en_i && as_prev_q && !ext_as_s)
    begin
      cap_d = ext_addr_s;
      hold_d = 1'b1;
    end
    else if (!ready_s || !grant_i)
      hold_d = 1'b0;
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      prev_addr_q <= '0;
      first_q <= 1'b1;
      grant_q <= 1'b0;
      hit_q <= 1'b0;
      as_prev_q <= 1'b1;
      hold_q <= 1'b0;
      cap_q <= '0;
    end
    else
    begin
      prev_addr_q <= prev_addr_d;
      first_q <= first_d;
      grant_q <= grant_i;
      hit_q <= hit_d;
      as_prev_q <= ext_as_s;
      hold_q <= hold_d;
      cap_q <= cap_d;
    end
  end
  // ---------------------------------------------------------------
  // Refresh timer on the input clock
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q, cnt_d; // Down counter
  logic [1:0] pulse_q, pulse_d;   // Overflow clocks left
  always_comb
  begin
    cnt_d = preload_i[CNT_W-1:0];
    pulse_d = (pulse_q != 2'h0) ? pulse_q - 2'h1 : 2'h0;
    if (system_support_control_settings_i[SYSTEM_SUPPORT_CONTROL_SETTINGS_REFRESH_EN_BIT])
    begin
      if (cnt_q == '0)
        pulse_d = preload_i[PRELOAD_WIDTH_BIT] ? OVF_LONG : OVF_SHORT;
      else
        cnt_d = cnt_q - 31'h1;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= '1;
      pulse_q <= 2'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
    end
  end
  // ---------------------------------------------------------------
  // Pin values and enables, registered each clock
  // ---------------------------------------------------------------
  logic dram_burst, breq;
  assign dram_burst = system_support_control_settings_i[SYSTEM_SUPPORT_CONTROL_SETTINGS_DRAM_BURST_BIT];
  assign breq = (bus_ctrl_i[0] && xact_burst_ok_i) || dram_burst;
  assign burst_mode_o = !ready_s && (!ack_s || dram_burst);
  always_ff @(posedge clk_i)
  begin
    // Values first; reset overrides below
    addr_o <= (grant_i && dram_area_i) ? mux_addr_i : (grant_i ? cap_q : core_addr_i);
    be_n_o <= be_n_i;
    as_n_o <= as_n_i;
    read_write_output_o <= read_write_output_i;
    asi_o <= asi_i;
    lock_n_o <= lock_n_i;
    cs_n_o <= cs_n_i;
    data_o <= data_i;
    error_n_o <= error_n_i;
    power_down_indication_n_o <= grant_i || !asleep_o;
    bus_grant_output_n_o <= !grant_i;
    page_hit_n_o <= !hit_d;
    burst_req_n_o <= grant_i || !breq;
    tovf_n_o <= (pulse_d == 2'h0);
    ras_n_o <= ras_n_i;
    // Column strobes: shared in two-write-enable, per lane otherwise
    if (two_we_i)
      cas_n_o <= {4{!cas_act_i}};
    else if (bus16_i)
      cas_n_o <= {!(cas_act_i && lane_i[1]), !(cas_act_i && lane_i[0]), 2'h3};
    else
      cas_n_o <= ~({lane_i[3], lane_i[2], lane_i[1], lane_i[0]} & {4{cas_act_i}});
    // Write enables: per lane in two-write-enable, shared otherwise
    dwe_n_o <= two_we_i ? ~(lane_i & {4{we_act_i}}) : {4{!we_act_i}};
    doe_n_o <= !oe_act_i;
    ctl_oe_o <= float_s;
    addr_oe_o <= float_s && (!grant_i || hold_d);
    be_oe_o <= float_s && !grant_i;
    bus_oe_o <= float_s && !grant_i;
    lock_oe_o <= float_s && !grant_i;
    cs_oe_o <= float_s && !grant_i;
    data_oe_o <= float_s && !grant_i && data_drive_i;
    if (sys_rst_i)
    begin
      as_n_o <= 1'b1;
      cs_n_o <= ALL_HIGH6;
      error_n_o <= 1'b1;
      lock_n_o <= 1'b1;
      power_down_indication_n_o <= 1'b1;
      bus_grant_output_n_o <= 1'b1;
      page_hit_n_o <= 1'b1;
      burst_req_n_o <= 1'b1;
      tovf_n_o <= 1'b1;
      read_write_output_o <= 1'b1;
      ras_n_o <= ALL_HIGH4;
      cas_n_o <= ALL_HIGH4;
      dwe_n_o <= ALL_HIGH4;
      doe_n_o <= 1'b1;
      addr_oe_o <= float_s;
      be_oe_o <= float_s;
      bus_oe_o <= float_s;
      lock_oe_o <= float_s;
      cs_oe_o <= float_s;
      data_oe_o <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  float_hiz_a: assert property (!float_s |=> !ctl_oe_o && !addr_oe_o && !data_oe_o)
    else $error("drivers not floated");
  burst_req_a: assert property (!grant_i && breq |=> !burst_req_n_o)
    else $error("burst request not asserted");
  dram_burst_a: assert property (!ready_s && dram_burst |-> burst_mode_o)
    else $error("dram burst not taken");
  page_first_a: assert property ($changed(grant_i) |=> page_hit_n_o ##1 page_hit_n_o)
    else $error("page hit right after handover");
  page_hit_a: assert property (cycle_start_i && !first_q && system_support_control_settings_i[SYSTEM_SUPPORT_CONTROL_SETTINGS_PAGE_EN_BIT]
    && (((core_addr_i ^ prev_addr_q) & page_mask_i) == '0) && grant_i == grant_q
    |=> !page_hit_n_o)
    else $error("page hit missed");
  cas_same_a: assert property (two_we_i && !sys_rst_i |=> $countones(cas_n_o) inside {0, 4})
    else $error("column strobes differ");
  dwe_same_a: assert property (!two_we_i && !sys_rst_i |=> $countones(dwe_n_o) inside {0, 4})
    else $error("write enables differ");
  ovf_long_a: assert property ($fell(tovf_n_o) && preload_i[PRELOAD_WIDTH_BIT]
    && $stable(preload_i) |-> !tovf_n_o [*3])
    else $error("long overflow pulse too short");
  ovf_fire_a: assert property (system_support_control_settings_i[SYSTEM_SUPPORT_CONTROL_SETTINGS_REFRESH_EN_BIT] && cnt_q == '0 |=> !tovf_n_o)
    else $error("overflow pulse missing");
  wake_exit_a: assert property (asleep_o && !wake_s ##1 !wake_s |=> !asleep_o)
    else $error("no wake after two clocks");
  grant_pins_a: assert property (grant_i |=> !bus_grant_output_n_o && !be_oe_o && !bus_oe_o
    && power_down_indication_n_o && burst_req_n_o)
    else $error("grant pin state wrong");
  reset_pins_a: assert property (@(posedge clk_i) sys_rst_i |=> as_n_o && power_down_indication_n_o
    && bus_grant_output_n_o && tovf_n_o && doe_n_o && (ras_n_o == ALL_HIGH4))
    else $error("reset pin state wrong");
  burst_ack_c: cover property (!ready_s && !ack_s && !dram_burst);
  ovf_c: cover property ($fell(tovf_n_o) && preload_i[PRELOAD_WIDTH_BIT]);
  wake_c: cover property ($fell(asleep_o));
  hit_c: cover property ($fell(page_hit_n_o));
endmodule

// [burst_dram_pin_interface_test.sv]
// Self-checking bench for the burst DRAM pin interface
module burst_dram_pin_interface_test
  import bdpi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Stimulus and observed signals
  // ----
  logic clk_i, sys_rst_i, float_n, grant, sleep_req, xact_ok, cstart, go, ack, slow;
  logic wake_req, dram_en, dram_area, ext_as_n, cas_act, we_act, oe_act, bus16, two_we;
  logic [3:0] lane, ras, ec, ew;
  logic [31:0] bus_ctrl, system_support_control_settings, preload, misc, data;
  logic [ADDR_W-1:0] caddr, mask, ext_addr, mux_addr;
  logic ready_n, ack_n, wake_n, burst_mode, asleep, addr_oe, be_oe, bus_oe, lock_oe;
  logic cs_oe, data_oe, ctl_oe, as_n, lock_n, error_n, power_down_indication_n, bus_grant_output_n, ph_n, breq_n;
  logic tovf_n, doe_n;
  logic [5:0] cs_n;
  logic [3:0] ras_n, cas_n, dwe_n;
  int err_total, n_compared, cyc, prev, lo, hi;
  // ----
  // Design and far-side model
  // ----
  bdpi_top i_bdpi_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wake_n_i(wake_n),
    .float_n_i(float_n), .burst_ack_n_i(ack_n), .ready_n_i(ready_n), .ext_as_n_i(ext_as_n),
    .ext_addr_i(ext_addr), .sleep_req_i(sleep_req), .grant_i(grant), .bus_ctrl_i(bus_ctrl),
    .xact_burst_ok_i(xact_ok), .system_support_control_settings_i(system_support_control_settings), .preload_i(preload), .page_mask_i(mask),
    .cycle_start_i(cstart), .core_addr_i(caddr), .be_n_i(misc[3:0]), .as_n_i(misc[4]),
    .read_write_output_i(misc[5]), .asi_i(misc[9:6]), .lock_n_i(misc[10]), .error_n_i(misc[11]),
    .cs_n_i(misc[17:12]), .data_i(data), .data_drive_i(misc[18]), .dram_ctrl_en_i(dram_en),
    .dram_area_i(dram_area), .mux_addr_i(mux_addr), .ras_n_i(ras), .cas_act_i(cas_act),
    .we_act_i(we_act), .oe_act_i(oe_act), .lane_i(lane), .bus16_i(bus16), .two_we_i(two_we),
    .burst_mode_o(burst_mode), .asleep_o(asleep), .addr_o(), .addr_oe_o(addr_oe),
    .be_n_o(), .be_oe_o(be_oe), .as_n_o(as_n), .read_write_output_o(), .asi_o(), .bus_oe_o(bus_oe),
    .lock_n_o(lock_n), .lock_oe_o(lock_oe), .cs_n_o(cs_n), .cs_oe_o(cs_oe), .data_o(),
    .data_oe_o(data_oe), .error_n_o(error_n), .power_down_indication_n_o(power_down_indication_n), .bus_grant_output_n_o(bus_grant_output_n),
    .page_hit_n_o(ph_n), .burst_req_n_o(breq_n), .tovf_n_o(tovf_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .dwe_n_o(dwe_n), .doe_n_o(doe_n), .ctl_oe_o(ctl_oe));
  bdpi_far_model i_bdpi_far_model (.clk_i(clk_i), .go_i(go), .ack_i(ack), .slow_i(slow),
    .wake_i(wake_req), .power_down_indication_n_i(power_down_indication_n), .ready_n_o(ready_n), .burst_ack_n_o(ack_n),
    .wake_n_o(wake_n));
  // ----
  // Clock, timeout and reporting
  // ----
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      results();
    end
  end
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    void'($urandom(5));
    {sys_rst_i, float_n, ext_as_n} = 3'h7;
    {grant, sleep_req, xact_ok, cstart, go, ack, slow, wake_req, dram_en} = '0;
    {dram_area, cas_act, we_act, oe_act, bus16, two_we, lane, ras} = '0;
    {bus_ctrl, system_support_control_settings, preload, caddr, mask} = '0;
    misc = $urandom();
    data = $urandom();
    ext_addr = ADDR_W'($urandom());
    mux_addr = ADDR_W'($urandom());
    // Reset pin levels
    repeat (6) @(negedge clk_i);
    chk("reset pins", 32'h7fffff, 32'({as_n, cs_n, error_n, lock_n, power_down_indication_n, bus_grant_output_n, ph_n,
      breq_n, tovf_n, ras_n, cas_n, doe_n}));
    chk("reset data enable", 32'h0, 32'(data_oe));
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    // Strobe and write enable lane mapping
    for (int k = 0; k < 24; k++)
    begin
      {cas_act, we_act, oe_act, two_we} = 4'($urandom());
      bus16 = !two_we && $urandom() % 2;
      lane = 4'($urandom());
      ras = 4'($urandom());
      @(negedge clk_i);
      ec = bus16 ? {~(lane[1:0] & {2{cas_act}}), 2'h3} : ~(lane & {4{cas_act}});
      if (two_we)
        ec = {4{!cas_act}};
      ew = two_we ? ~(lane & {4{we_act}}) : {4{!we_act}};
      chk("column strobes", 32'(ec), 32'(cas_n));
      chk("write enables", 32'(ew), 32'(dwe_n));
      chk("output enable", 32'(!oe_act), 32'(doe_n));
      chk("row strobes", 32'(ras), 32'(ras_n));
    end
    // Burst request and burst transfer decision
    for (int i = 0; i < 8; i++)
    begin
      bus_ctrl = 32'(i[0]);
      xact_ok = i[1];
      system_support_control_settings = 32'(i[2]) << SYSTEM_SUPPORT_CONTROL_SETTINGS_DRAM_BURST_BIT;
      ack = i[0] ^ i[1];
      slow = i[2];
      go = 1'b1;
      @(negedge clk_i);
      go = 1'b0;
      chk("burst request", 32'(!((i[0] && i[1]) || i[2])), 32'(breq_n));
      for (int t = 0; t < 10 && ready_n !== 1'b0; t++)
        @(negedge clk_i);
      repeat (3) @(negedge clk_i);
      chk("burst mode", 32'(i[2] || ack), 32'(burst_mode));
      repeat (6) @(negedge clk_i);
    end
    // Page-hit detection, last access under bus grant
    mask = '1;
    prev = -1;
    for (int j = 0; j < 5; j++)
    begin
      caddr = (j < 2) ? ext_addr : mux_addr;
      system_support_control_settings = 32'(j != 3) << SYSTEM_SUPPORT_CONTROL_SETTINGS_PAGE_EN_BIT;
      grant = (j == 4);
      cstart = 1'b1;
      @(negedge clk_i);
      cstart = 1'b0;
      chk("page hit", 32'(!(j != 3 && !grant && int'(caddr) == prev)), 32'(ph_n));
      prev = int'(caddr);
    end
    chk("grant pins", 32'h7, 32'({bus_grant_output_n, be_oe, lock_oe, bus_oe, cs_oe, addr_oe, power_down_indication_n,
      breq_n, ctl_oe}));
    grant = 1'b0;
    system_support_control_settings = 32'h0;
    repeat (4) @(negedge clk_i);
    // Refresh overflow pulse width and period
    for (int w = 0; w < 2; w++)
    begin
      preload = {w[0], 31'h5};
      system_support_control_settings = 32'h1 << SYSTEM_SUPPORT_CONTROL_SETTINGS_REFRESH_EN_BIT;
      for (int t = 0; t < 40 && tovf_n !== 1'b0; t++)
        @(negedge clk_i);
      lo = 0;
      hi = 0;
      while (tovf_n === 1'b0 && lo < 9)
      begin
        lo++;
        @(negedge clk_i);
      end
      while (tovf_n === 1'b1 && hi < 20)
      begin
        hi++;
        @(negedge clk_i);
      end
      chk("overflow width", w ? 3 : 1, lo);
      chk("overflow period", 6, lo + hi);
      system_support_control_settings = 32'h0;
      repeat (4) @(negedge clk_i);
    end
    // Sleep entry and wake pulse
    sleep_req = 1'b1;
    @(negedge clk_i);
    sleep_req = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("sleep state", 32'h2, 32'({asleep, power_down_indication_n}));
    wake_req = 1'b1;
    @(negedge clk_i);
    wake_req = 1'b0;
    for (int t = 0; t < 12 && asleep !== 1'b0; t++)
      @(negedge clk_i);
    @(negedge clk_i);
    chk("woken state", 32'h1, 32'({asleep, power_down_indication_n}));
    // Float puts every driver off
    float_n = 1'b0;
    repeat (5) @(negedge clk_i);
    chk("float enables", 32'h0, 32'({ctl_oe, bus_oe, addr_oe, be_oe, lock_oe, cs_oe,
      data_oe}));
    float_n = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("drive restored", 32'h1, 32'(ctl_oe));
    results();
  end
endmodule
